// >>> hw/frac_ctrl.sv
/*
 Control field bank of a fractional-N synthesizer behind a three-wire
 serial load port. Assumes the host stops the serial clock while the
 load strobe is high, so the shifted word is steady when taken.
*/
`timescale 1ns/1ps
`default_nettype none
module frac_ctrl (
    // System clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // Three-wire serial load port
    input wire logic LINK_CLK,
    input wire logic SER_DATA,
    input wire logic SER_LOAD,
    // Loop polarity and charge pump state
    output logic MAIN_PD_POLARITY,
    output logic AUX_PD_POLARITY,
    output logic MAIN_PUMP_HIZ,
    output logic AUX_PUMP_HIZ,
    // Automatic power-up pulses
    output logic MAIN_AUTO_PWRUP,
    output logic AUX_AUTO_PWRUP,
    // Modulator and fraction
    output logic MOD_ENABLE,
    output logic [2:0] MOD_ORDER,
    output logic FRAC_WIDE,
    output logic [21:0] FRAC_NUMERATOR,
    output logic [21:0] FRAC_DENOMINATOR
);
    // ==========================================================
    // Link domain: shift in while the load strobe is low
    logic [frac_ctrl_pkg::WORD_W-1:0] shift_r;

    // Strobe shares the host's timing, so no synchroniser here
    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            shift_r <= '0;
        end else if (!SER_LOAD) begin
            shift_r <= {shift_r[frac_ctrl_pkg::WORD_W-2:0], SER_DATA};
        end
    end

    // ==========================================================
    // System domain: strobe synchroniser and edge detect
    logic load_s1_r;
    logic load_s2_r;
    logic load_d_r;
    logic load_rise;

    // First stage feeds only the second; reset to the strobe's idle
    // high level, so leaving reset never looks like a load rise
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            load_s1_r <= 1'b1;
            load_s2_r <= 1'b1;
            load_d_r <= 1'b1;
        end else begin
            load_s1_r <= SER_LOAD;
            load_s2_r <= load_s1_r;
            load_d_r <= load_s2_r;
        end
    end

    assign load_rise = load_s2_r & ~load_d_r;

    // ==========================================================
    // Load sequencer
    frac_ctrl_pkg::load_state_t state_r;
    frac_ctrl_pkg::load_state_t state_nxt;
    logic [frac_ctrl_pkg::WORD_W-1:0] word_r;

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            frac_ctrl_pkg::ST_IDLE: begin
                if (load_rise) begin
                    state_nxt = frac_ctrl_pkg::ST_TAKE;
                end
            end
            frac_ctrl_pkg::ST_TAKE: state_nxt = frac_ctrl_pkg::ST_APPLY;
            frac_ctrl_pkg::ST_APPLY: state_nxt = frac_ctrl_pkg::ST_IDLE;
            default: state_nxt = frac_ctrl_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= frac_ctrl_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Word is quiet here: the link clock stands while strobe is high
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            word_r <= '0;
        end else if (state_r == frac_ctrl_pkg::ST_TAKE) begin
            word_r <= shift_r;
        end
    end

    // ==========================================================
    // Address decode, valid only in the apply state
    logic apply;
    logic wr_main;
    logic wr_den;
    logic wr_cfg;
    logic wr_ext;

    assign apply = (state_r == frac_ctrl_pkg::ST_APPLY);
    assign wr_main = apply & (word_r[0] == frac_ctrl_pkg::CODE_MAIN_DIV);
    assign wr_den = apply &
        (word_r[frac_ctrl_pkg::CODE_W-1:0] == frac_ctrl_pkg::CODE_DEN_BASE);
    assign wr_cfg = apply &
        (word_r[frac_ctrl_pkg::CODE_W-1:0] == frac_ctrl_pkg::CODE_CONFIG);
    assign wr_ext = apply &
        (word_r[frac_ctrl_pkg::CODE_W-1:0] == frac_ctrl_pkg::CODE_FRAC_EXT);

    // ==========================================================
    // Configuration word fields
    frac_ctrl_pkg::auto_power_up_select_t auto_power_up_select_r;
    frac_ctrl_pkg::fm_t fm_r;
    logic fdm_r;
    logic aux_pol_r;
    logic main_pol_r;

    // Polarity, order, width and power-up selects
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            auto_power_up_select_r <= frac_ctrl_pkg::auto_power_up_select_t'(frac_ctrl_pkg::AUTO_POWER_UP_SELECT_RST);
            fm_r <= frac_ctrl_pkg::fm_t'(frac_ctrl_pkg::FM_RST);
            fdm_r <= frac_ctrl_pkg::FDM_RST;
            aux_pol_r <= frac_ctrl_pkg::POL_RST;
            main_pol_r <= frac_ctrl_pkg::POL_RST;
        end else if (wr_cfg) begin
            auto_power_up_select_r <= frac_ctrl_pkg::auto_power_up_select_t'(
                word_r[frac_ctrl_pkg::AUTO_POWER_UP_SELECT_LSB +: 2]);
            fm_r <= frac_ctrl_pkg::fm_t'(
                word_r[frac_ctrl_pkg::FM_LSB +: 2]);
            fdm_r <= word_r[frac_ctrl_pkg::FDM_BIT];
            aux_pol_r <= word_r[frac_ctrl_pkg::AUX_POL_BIT];
            main_pol_r <= word_r[frac_ctrl_pkg::MAIN_POL_BIT];
        end
    end

    // ==========================================================
    // Automatic power-up on a main divider write
    logic up_main;
    logic up_aux;
    logic main_up_r;
    logic aux_up_r;

    // Reserved code behaves as no power-up
    assign up_main = wr_main & ((auto_power_up_select_r == frac_ctrl_pkg::AUTO_POWER_UP_SELECT_MAIN) |
        (auto_power_up_select_r == frac_ctrl_pkg::AUTO_POWER_UP_SELECT_BOTH));
    assign up_aux = wr_main & (auto_power_up_select_r == frac_ctrl_pkg::AUTO_POWER_UP_SELECT_BOTH);

    // One-cycle pulses to the loop power logic
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            main_up_r <= 1'b0;
            aux_up_r <= 1'b0;
        end else begin
            main_up_r <= up_main;
            aux_up_r <= up_aux;
        end
    end

    // ==========================================================
    // Charge pump high impedance, overridden by power-up
    logic main_hiz_r;
    logic aux_hiz_r;

    // Power-up wakes the pump, beating the stored bit
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            main_hiz_r <= frac_ctrl_pkg::HIZ_RST;
            aux_hiz_r <= frac_ctrl_pkg::HIZ_RST;
        end else if (wr_cfg) begin
            main_hiz_r <= word_r[frac_ctrl_pkg::MAIN_HIZ_BIT];
            aux_hiz_r <= word_r[frac_ctrl_pkg::AUX_HIZ_BIT];
        end else begin
            if (up_main) begin
                main_hiz_r <= 1'b0;
            end
            if (up_aux) begin
                aux_hiz_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Fraction base and extension fields
    logic [frac_ctrl_pkg::BASE_W-1:0] num_base_r;
    logic [frac_ctrl_pkg::BASE_W-1:0] den_base_r;
    logic [frac_ctrl_pkg::EXT_W-1:0] num_ext_r;
    logic [frac_ctrl_pkg::EXT_W-1:0] den_ext_r;

    // Base fields
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            num_base_r <= '0;
            den_base_r <= '0;
        end else begin
            if (wr_main) begin
                num_base_r <= word_r[frac_ctrl_pkg::NUM_BASE_LSB +:
                    frac_ctrl_pkg::BASE_W];
            end
            if (wr_den) begin
                den_base_r <= word_r[frac_ctrl_pkg::DEN_BASE_LSB +:
                    frac_ctrl_pkg::BASE_W];
            end
        end
    end

    // One write moves both extensions, so no mixed fraction
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            num_ext_r <= '0;
            den_ext_r <= '0;
        end else if (wr_ext) begin
            num_ext_r <= word_r[frac_ctrl_pkg::NUM_EXT_LSB +:
                frac_ctrl_pkg::EXT_W];
            den_ext_r <= word_r[frac_ctrl_pkg::DEN_EXT_LSB +:
                frac_ctrl_pkg::EXT_W];
        end
    end

    // ==========================================================
    // Assembled fraction and modulator order
    logic [frac_ctrl_pkg::FRAC_W-1:0] numer_r;
    logic [frac_ctrl_pkg::FRAC_W-1:0] denom_r;
    logic [2:0] order_r;
    logic mod_en_r;

    // Narrow mode drops the extensions; host keeps them zero below
    // 4096 in wide mode, nothing here checks it
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            numer_r <= '0;
            denom_r <= '0;
        end else if (fdm_r) begin
            numer_r <= {num_ext_r, num_base_r};
            denom_r <= {den_ext_r, den_base_r};
        end else begin
            numer_r <= {{frac_ctrl_pkg::EXT_W{1'b0}},
                num_base_r};
            denom_r <= {{frac_ctrl_pkg::EXT_W{1'b0}}, den_base_r};
        end
    end

    // Order decode; off means the modulator is bypassed
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            order_r <= frac_ctrl_pkg::ORDER_4;
        end else begin
            case (fm_r)
                frac_ctrl_pkg::FM_FOURTH: order_r <= frac_ctrl_pkg::ORDER_4;
                frac_ctrl_pkg::FM_OFF: order_r <= frac_ctrl_pkg::ORDER_OFF;
                frac_ctrl_pkg::FM_SECOND: order_r <= frac_ctrl_pkg::ORDER_2;
                frac_ctrl_pkg::FM_THIRD: order_r <= frac_ctrl_pkg::ORDER_3;
                default: order_r <= frac_ctrl_pkg::ORDER_4;
            endcase
        end
    end

    // Enable kept in a flop beside the order, so both move together
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mod_en_r <= (frac_ctrl_pkg::FM_RST != frac_ctrl_pkg::FM_OFF);
        end else begin
            mod_en_r <= (fm_r != frac_ctrl_pkg::FM_OFF);
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops
    assign MAIN_PD_POLARITY = main_pol_r;
    assign AUX_PD_POLARITY = aux_pol_r;
    assign MAIN_PUMP_HIZ = main_hiz_r;
    assign AUX_PUMP_HIZ = aux_hiz_r;
    assign MAIN_AUTO_PWRUP = main_up_r;
    assign AUX_AUTO_PWRUP = aux_up_r;
    assign MOD_ENABLE = mod_en_r;
    assign MOD_ORDER = order_r;
    assign FRAC_WIDE = fdm_r;
    assign FRAC_NUMERATOR = numer_r;
    assign FRAC_DENOMINATOR = denom_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    auto_power_up_select_main_a: assert property (
        wr_main && auto_power_up_select_r == frac_ctrl_pkg::AUTO_POWER_UP_SELECT_MAIN
        |=> MAIN_AUTO_PWRUP && !AUX_AUTO_PWRUP)
        else $error("main-only power-up pulse wrong");

    auto_power_up_select_both_a: assert property (
        wr_main && auto_power_up_select_r == frac_ctrl_pkg::AUTO_POWER_UP_SELECT_BOTH
        |=> MAIN_AUTO_PWRUP && AUX_AUTO_PWRUP ##1
        !MAIN_AUTO_PWRUP && !AUX_AUTO_PWRUP)
        else $error("dual power-up pulse wrong");

    auto_power_up_select_none_a: assert property (
        (auto_power_up_select_r == frac_ctrl_pkg::AUTO_POWER_UP_SELECT_NONE ||
        auto_power_up_select_r == frac_ctrl_pkg::AUTO_POWER_UP_SELECT_RSVD) && !wr_cfg
        |=> !MAIN_AUTO_PWRUP && !AUX_AUTO_PWRUP)
        else $error("power-up pulse without selection");

    hiz_override_a: assert property (
        MAIN_AUTO_PWRUP |-> !MAIN_PUMP_HIZ &&
        (!AUX_AUTO_PWRUP || !AUX_PUMP_HIZ))
        else $error("pump left high impedance at power-up");

    pump_hiz_a: assert property (
        wr_cfg |=> MAIN_PUMP_HIZ ==
        $past(word_r[frac_ctrl_pkg::MAIN_HIZ_BIT]) &&
        AUX_PUMP_HIZ == $past(word_r[frac_ctrl_pkg::AUX_HIZ_BIT]))
        else $error("pump state not taken from word");

    polarity_a: assert property (
        wr_cfg |=> MAIN_PD_POLARITY ==
        $past(word_r[frac_ctrl_pkg::MAIN_POL_BIT]) &&
        AUX_PD_POLARITY == $past(word_r[frac_ctrl_pkg::AUX_POL_BIT]))
        else $error("polarity not taken from word");

    order_sel_a: assert property (
        wr_cfg && word_r[frac_ctrl_pkg::FM_LSB +: 2] !=
        frac_ctrl_pkg::FM_OFF |=> ##1 MOD_ENABLE &&
        MOD_ORDER != frac_ctrl_pkg::ORDER_OFF)
        else $error("modulator order not set");

    order_map_a: assert property (
        fm_r == frac_ctrl_pkg::FM_SECOND |=>
        MOD_ORDER == frac_ctrl_pkg::ORDER_2)
        else $error("second order not selected");

    mod_off_a: assert property (
        fm_r == frac_ctrl_pkg::FM_OFF |=> !MOD_ENABLE)
        else $error("modulator not disabled");

    narrow_frac_a: assert property (
        !fdm_r [*2] |-> FRAC_NUMERATOR <= 22'h000fff &&
        FRAC_DENOMINATOR <= 22'h000fff)
        else $error("narrow fraction above 4095");

    wide_frac_a: assert property (
        wr_ext && fdm_r |=> ##1 FRAC_NUMERATOR[21:12] ==
        $past(word_r[13:4], 2) &&
        FRAC_DENOMINATOR[21:12] == $past(word_r[23:14], 2))
        else $error("wide extension not placed above base");

    ext_pair_a: assert property (
        !wr_ext |=> $stable(num_ext_r) && $stable(den_ext_r))
        else $error("extension changed without its write");

    cover_both_c: cover property (
        wr_main && auto_power_up_select_r == frac_ctrl_pkg::AUTO_POWER_UP_SELECT_BOTH);
    cover_wide_c: cover property (wr_ext && fdm_r);
    cover_off_c: cover property (fm_r == frac_ctrl_pkg::FM_OFF);
    cover_load_c: cover property (load_rise ##2 wr_cfg);
endmodule
`default_nettype wire

// >>> hw/frac_ctrl_pkg.sv
/*
 Constants and types of the fractional synthesizer control fields.
 Assumes 24-bit serial words, data first, address bits in bits 3:0, except the main divider word, addressed by bit 0 alone.
*/
// Function
// - Auto power-up: none, main, both, reserved.
// - Auto power-up overrides charge pump high impedance.
// - Order field: 0 fourth, 2 second, 3 third.
// - Order value 1 disables modulator; test only.
// - Narrow mode: 12-bit fractions, largest 4095.
// - Wide mode: 22-bit fractions, largest 4194303.
// - Aux polarity bit 1 positive, 0 negative.
// - Main polarity bit 1 positive, normally used.
// - Aux pump bit 1 high impedance.
// - Main pump bit 1 high impedance.
// - Narrow numerator uses base field only.
// - Wide numerator: extension above base field.
// - Narrow denominator uses base field only.
// - Wide denominator: extension above base field.
package frac_ctrl_pkg;
    // ==========================================================
    // Serial word layout
    localparam int WORD_W = 24;
    localparam int CODE_W = 4;
    localparam logic [0:0] CODE_MAIN_DIV = 1'h0;
    localparam logic [3:0] CODE_DEN_BASE = 4'h3;
    localparam logic [3:0] CODE_CONFIG = 4'hb;
    localparam logic [3:0] CODE_FRAC_EXT = 4'hd;
    // ==========================================================
    // Field positions
    localparam int BASE_W = 12;
    localparam int EXT_W = 10;
    localparam int FRAC_W = 22;
    localparam int NUM_BASE_LSB = 1;
    localparam int DEN_BASE_LSB = 4;
    localparam int AUTO_POWER_UP_SELECT_LSB = 10;
    localparam int FM_LSB = 12;
    localparam int FDM_BIT = 14;
    localparam int AUX_POL_BIT = 15;
    localparam int AUX_HIZ_BIT = 16;
    localparam int MAIN_POL_BIT = 17;
    localparam int MAIN_HIZ_BIT = 18;
    localparam int NUM_EXT_LSB = 4;
    localparam int DEN_EXT_LSB = 14;
    // ==========================================================
    // Reset values and modulator order codes
    localparam logic [1:0] AUTO_POWER_UP_SELECT_RST = 2'h0;
    localparam logic [1:0] FM_RST = 2'h0;
    localparam logic POL_RST = 1'h1;
    localparam logic HIZ_RST = 1'h0;
    localparam logic FDM_RST = 1'h0;
    localparam logic [2:0] ORDER_OFF = 3'h0;
    localparam logic [2:0] ORDER_2 = 3'h2;
    localparam logic [2:0] ORDER_3 = 3'h3;
    localparam logic [2:0] ORDER_4 = 3'h4;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        AUTO_POWER_UP_SELECT_NONE = 2'h0,
        AUTO_POWER_UP_SELECT_MAIN = 2'h1,
        AUTO_POWER_UP_SELECT_BOTH = 2'h2,
        AUTO_POWER_UP_SELECT_RSVD = 2'h3
    } auto_power_up_select_t;
    typedef enum logic [1:0] {
        FM_FOURTH = 2'h0,
        FM_OFF = 2'h1,
        FM_SECOND = 2'h2,
        FM_THIRD = 2'h3
    } fm_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TAKE = 3'b010,
        ST_APPLY = 3'b100
    } load_state_t;
endpackage

// >>> sim/ser_host_model.sv
/*
 Host side of the three-wire serial load port: shifts 24-bit words.
 Assumes the bench calls send from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_host_model (
    // Serial load port towards the device
    output var logic link_clk,
    output var logic ser_data,
    output var logic ser_load
);
    // =========================================================
    // Idle state
    // The clock stands still outside frames and the strobe rests high
    initial begin
        link_clk = 1'b0;
        ser_data = 1'b1;
        ser_load = 1'b1;
    end

    // =========================================================
    // One frame, first bit lands in bit 23, 32 ns link period
    task automatic send(input logic [23:0] w);
        #3;
        ser_load = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            #16 link_clk = 1'b1;
            #16 link_clk = 1'b0;
        end
        #5;
        ser_load = 1'b1;
        // Line released: show the inverse so a stale bit cannot pass
        ser_data = ~ser_data;
        // Strobe stays high well past the five-cycle take window
        #100;
    endtask
endmodule
`default_nettype wire

// >>> sim/frac_pll_control_fields_tb.sv
/*
 Self-checking bench of the fractional synthesizer control fields.
 Assumes frac_ctrl and frac_ctrl_pkg compiled first, host model beside.
*/
`timescale 1ns/1ps
`default_nettype none
module frac_pll_control_fields_tb;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    wire logic link_clk;
    wire logic ser_data;
    wire logic ser_load;
    logic main_pol, aux_pol, main_hiz, aux_hiz, main_pu, aux_pu;
    logic mod_en, wide_o;
    logic [2:0] order_o;
    logic [21:0] num_o, den_o;
    int miscompares = 0;
    int n_compared = 0;
    int n_main = 0;
    int n_aux = 0;
    // Shadow copy of what the host last wrote
    logic s_mpol = 1'b1, s_apol = 1'b1, s_mhiz = 1'b0, s_ahiz = 1'b0;
    logic s_wide = 1'b0;
    logic [1:0] s_fm = 2'h0;
    logic [11:0] s_nb = 12'h000, s_db = 12'h000;
    logic [9:0] s_ne = 10'h000, s_de = 10'h000;

    // =========================================================
    // Clock, design and host
    always #4 sys_clk = ~sys_clk;

    frac_ctrl dut (
        .SYS_CLK(sys_clk), .ARST_N(arst_n),
        .LINK_CLK(link_clk), .SER_DATA(ser_data), .SER_LOAD(ser_load),
        .MAIN_PD_POLARITY(main_pol), .AUX_PD_POLARITY(aux_pol),
        .MAIN_PUMP_HIZ(main_hiz), .AUX_PUMP_HIZ(aux_hiz),
        .MAIN_AUTO_PWRUP(main_pu), .AUX_AUTO_PWRUP(aux_pu),
        .MOD_ENABLE(mod_en), .MOD_ORDER(order_o), .FRAC_WIDE(wide_o),
        .FRAC_NUMERATOR(num_o), .FRAC_DENOMINATOR(den_o)
    );

    ser_host_model host (
        .link_clk(link_clk), .ser_data(ser_data), .ser_load(ser_load)
    );

    // Pulses last one cycle, so count them at the settled falling edge
    always @(negedge sys_clk) begin
        if (main_pu === 1'b1) n_main++;
        if (aux_pu === 1'b1) n_aux++;
    end

    // =========================================================
    // Compare, access and report tasks
    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Fixed settle: sync, take, apply and two output stages fit in 12
    task automatic put(input logic [23:0] w);
        host.send(w);
        repeat (12) @(negedge sys_clk);
    endtask

    task automatic wr_cfg(input logic [1:0] pu);
        put({5'h00, s_mhiz, s_mpol, s_ahiz, s_apol, s_wide, s_fm, pu,
             6'h00, frac_ctrl_pkg::CODE_CONFIG});
    endtask

    task automatic wr_ext;
        put({s_de, s_ne, frac_ctrl_pkg::CODE_FRAC_EXT});
    endtask

    task automatic wr_den;
        put({8'h00, s_db, frac_ctrl_pkg::CODE_DEN_BASE});
    endtask

    task automatic wr_main;
        put({11'h000, s_nb, frac_ctrl_pkg::CODE_MAIN_DIV});
    endtask

    task automatic check_all;
        logic [2:0] ord;
        ord = (s_fm == 2'h0) ? frac_ctrl_pkg::ORDER_4 :
              (s_fm == 2'h1) ? frac_ctrl_pkg::ORDER_OFF : {1'b0, s_fm};
        chk(22'(main_pol), 22'(s_mpol));
        chk(22'(aux_pol), 22'(s_apol));
        chk(22'(main_hiz), 22'(s_mhiz));
        chk(22'(aux_hiz), 22'(s_ahiz));
        chk(22'(wide_o), 22'(s_wide));
        chk(22'(order_o), 22'(ord));
        chk(22'(mod_en), 22'(s_fm != 2'h1));
        chk(num_o, s_wide ? {s_ne, s_nb} : {10'h000, s_nb});
        chk(den_o, s_wide ? {s_de, s_db} : {10'h000, s_db});
    endtask

    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // =========================================================
    // Main sequence
    initial begin
        repeat (16) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check_all;
        $display("test reset values done");
        // Every order code, with polarity and pump bits walked along
        for (int i = 0; i < 4; i++) begin
            s_fm = 2'(i);
            s_mpol = i[0];
            s_apol = ~i[0];
            s_mhiz = i[1];
            s_ahiz = i[0] ^ i[1];
            wr_cfg(2'h0);
            check_all;
        end
        $display("test orders and pump bits done");
        // Narrow mode must ignore a nonzero extension
        s_fm = 2'h0;
        s_mhiz = 1'b0;
        s_ahiz = 1'b0;
        s_ne = 10'h2aa;
        s_de = 10'h155;
        wr_cfg(2'h0);
        wr_ext;
        s_nb = 12'hfff;
        wr_main;
        s_db = 12'h001;
        wr_den;
        check_all;
        $display("test narrow mode done");
        // Wide mode: extensions placed above base fields
        s_wide = 1'b1;
        wr_cfg(2'h0);
        check_all;
        s_nb = 12'h000;
        s_db = 12'hfff;
        wr_main;
        wr_den;
        s_ne = 10'h001;
        s_de = 10'h3ff;
        wr_ext;
        check_all;
        s_ne = 10'h000;
        s_de = 10'h000;
        s_nb = 12'h005;
        wr_ext;
        wr_main;
        check_all;
        $display("test wide mode done");
        // Auto power-up codes against both pumps held in high impedance
        for (int a = 0; a < 4; a++) begin
            s_mhiz = 1'b1;
            s_ahiz = 1'b1;
            n_main = 0;
            n_aux = 0;
            wr_cfg(2'(a));
            chk(22'(n_main + n_aux), 22'h0);
            wr_main;
            chk(22'(n_main), 22'(a == 1 || a == 2));
            chk(22'(n_aux), 22'(a == 2));
            s_mhiz = !(a == 1 || a == 2);
            s_ahiz = !(a == 2);
            check_all;
        end
        $display("test auto power-up done");
        results;
    end
endmodule
`default_nettype wire
